// *** verilog/iop_top.sv ***
// Pull masks, two PWM lines, join LED blink and signal-strength hold timer
`timescale 1ns/1ps
`include "iop_defines.svh"
module iop_top #(
  parameter int unsigned BLINK_STEP_CYC = `IOP_BLINK_STEP_CYC,
  parameter int unsigned HOLD_STEP_CYC = `IOP_HOLD_STEP_CYC
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic param_wr_en,
  input wire iop_pkg::iop_param_t param_wr_sel,
  input wire logic [19:0] param_wdata,
  input wire iop_pkg::iop_param_t param_rd_sel,
  output logic [19:0] param_rdata,
  input wire logic [2:0] line_five_function,
  input wire logic [2:0] line_ten_function,
  input wire logic [2:0] line_eleven_function,
  input wire logic sleep_coordinator,
  input wire logic tx_done,
  input wire logic rssi_valid,
  input wire logic [7:0] rssi_level,
  output logic [19:0] io_pull_up,
  output logic [19:0] io_pull_down,
  output logic first_pwm_output,
  output logic second_pwm_output,
  output logic join_led
);

  // --------------------------------------------------------------------
  // Parameter registers
  // --------------------------------------------------------------------
  logic [19:0] pull_en_r;  // Pull enable mask
  logic [19:0] pull_en_nxt;
  logic [19:0] pull_dir_r; // Pull direction mask
  logic [19:0] pull_dir_nxt;
  logic [9:0] duty0_r;     // First PWM duty
  logic [9:0] duty0_nxt;
  logic [9:0] duty1_r;     // Second PWM duty
  logic [9:0] duty1_nxt;
  logic [7:0] blink_r;     // Blink time setting
  logic [7:0] blink_nxt;
  logic [7:0] hold_r;      // Hold time setting
  logic [7:0] hold_nxt;
  logic [19:0] rdata_nxt;  // Readback value

  // Store writes; short blink times are refused
  always_comb begin
    pull_en_nxt = pull_en_r;
    pull_dir_nxt = pull_dir_r;
    duty0_nxt = duty0_r;
    duty1_nxt = duty1_r;
    blink_nxt = blink_r;
    hold_nxt = hold_r;
    if (param_wr_en) begin
      unique case (param_wr_sel)
        iop_pkg::IOP_SEL_PULL_EN: pull_en_nxt = param_wdata;
        iop_pkg::IOP_SEL_PULL_DIR: pull_dir_nxt = param_wdata;
        iop_pkg::IOP_SEL_DUTY0: duty0_nxt = param_wdata[9:0];
        iop_pkg::IOP_SEL_DUTY1: duty1_nxt = param_wdata[9:0];
        iop_pkg::IOP_SEL_BLINK: begin
          // Zero or 0x14 and above only
          if (param_wdata[7:0] == 8'h00 ||
              param_wdata[7:0] >= `IOP_BLINK_MIN) begin
            blink_nxt = param_wdata[7:0];
          end
        end
        iop_pkg::IOP_SEL_HOLD: hold_nxt = param_wdata[7:0];
        default: ;
      endcase
    end
  end

  // Readback multiplexer
  always_comb begin
    unique case (param_rd_sel)
      iop_pkg::IOP_SEL_PULL_EN: rdata_nxt = pull_en_r;
      iop_pkg::IOP_SEL_PULL_DIR: rdata_nxt = pull_dir_r;
      iop_pkg::IOP_SEL_DUTY0: rdata_nxt = {10'h000, duty0_r};
      iop_pkg::IOP_SEL_DUTY1: rdata_nxt = {10'h000, duty1_r};
      iop_pkg::IOP_SEL_BLINK: rdata_nxt = {12'h000, blink_r};
      iop_pkg::IOP_SEL_HOLD: rdata_nxt = {12'h000, hold_r};
      default: rdata_nxt = 20'h00000;
    endcase
  end

  // Register parameters and readback
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pull_en_r <= `IOP_PULL_EN_RST;
      pull_dir_r <= `IOP_PULL_DIR_RST;
      duty0_r <= `IOP_DUTY_RST;
      duty1_r <= `IOP_DUTY_RST;
      blink_r <= `IOP_BLINK_RST;
      hold_r <= `IOP_HOLD_RST;
      param_rdata <= 20'h00000;
    end else begin
      pull_en_r <= pull_en_nxt;
      pull_dir_r <= pull_dir_nxt;
      duty0_r <= duty0_nxt;
      duty1_r <= duty1_nxt;
      blink_r <= blink_nxt;
      hold_r <= hold_nxt;
      param_rdata <= rdata_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Pull resistor drive per I/O line
  // --------------------------------------------------------------------
  logic [19:0] pull_up_nxt;
  logic [19:0] pull_down_nxt;

  // Route each mask bit to its line, direction picks up or down
  always_comb begin
    pull_up_nxt = 20'h00000;
    pull_down_nxt = 20'h00000;
    for (int i = 0; i < `IOP_LINES; i++) begin
      pull_up_nxt[iop_pkg::iop_line_of_bit(5'(i))] =
        pull_en_r[i] & pull_dir_r[i];
      pull_down_nxt[iop_pkg::iop_line_of_bit(5'(i))] =
        pull_en_r[i] & ~pull_dir_r[i];
    end
  end

  // Register pull drive
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      io_pull_up <= 20'h00000;
      io_pull_down <= 20'h00000;
    end else begin
      io_pull_up <= pull_up_nxt;
      io_pull_down <= pull_down_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Signal-strength hold timer
  // --------------------------------------------------------------------
  iop_pkg::iop_hold_st_t hold_st_r; // Timer state
  iop_pkg::iop_hold_st_t hold_st_nxt;
  logic [23:0] hold_pre_r;  // Cycles within a 100 ms step
  logic [23:0] hold_pre_nxt;
  logic [7:0] hold_steps_r; // Steps elapsed
  logic [7:0] hold_steps_nxt;
  logic [9:0] rssi_duty_r;  // Scaled strength
  logic [9:0] rssi_duty_nxt;
  logic rssi_active;        // Strength output allowed

  // Count 100 ms steps after each transmission
  always_comb begin
    hold_st_nxt = hold_st_r;
    hold_pre_nxt = hold_pre_r;
    hold_steps_nxt = hold_steps_r;
    rssi_duty_nxt = rssi_duty_r;
    if (rssi_valid) begin
      // Stretch 8 bits over the 10-bit range
      rssi_duty_nxt = {rssi_level, rssi_level[7:6]};
    end
    if (tx_done) begin
      hold_st_nxt = iop_pkg::IOP_HOLD_RUN;
      hold_pre_nxt = 24'h000000;
      hold_steps_nxt = 8'h00;
    end else begin
      unique case (hold_st_r)
        iop_pkg::IOP_HOLD_IDLE: ;
        iop_pkg::IOP_HOLD_RUN: begin
          if (hold_r == `IOP_HOLD_FOREVER) begin
            hold_st_nxt = iop_pkg::IOP_HOLD_RUN;
          end else if (hold_steps_r >= hold_r) begin
            hold_st_nxt = iop_pkg::IOP_HOLD_IDLE;
          end else if (hold_pre_r == 24'(HOLD_STEP_CYC - 1)) begin
            hold_pre_nxt = 24'h000000;
            hold_steps_nxt = hold_steps_r + 8'h01;
          end else begin
            hold_pre_nxt = hold_pre_r + 24'h000001;
          end
        end
        default: hold_st_nxt = iop_pkg::IOP_HOLD_IDLE;
      endcase
    end
  end

  // Register hold timer
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hold_st_r <= iop_pkg::IOP_HOLD_IDLE;
      hold_pre_r <= 24'h000000;
      hold_steps_r <= 8'h00;
      rssi_duty_r <= 10'h000;
    end else begin
      hold_st_r <= hold_st_nxt;
      hold_pre_r <= hold_pre_nxt;
      hold_steps_r <= hold_steps_nxt;
      rssi_duty_r <= rssi_duty_nxt;
    end
  end

  // 0xFF means always on
  assign rssi_active = (hold_r == `IOP_HOLD_FOREVER) ||
                       (hold_st_r == iop_pkg::IOP_HOLD_RUN);

  // --------------------------------------------------------------------
  // PWM channels and line multiplexers
  // --------------------------------------------------------------------
  iop_pwm_if first_pwm_output_if ();
  iop_pwm_if second_pwm_output_if ();

  // Line ten takes strength or plain duty
  assign first_pwm_output_if.duty =
    (line_ten_function == `IOP_FN_RSSI_PWM) ? rssi_duty_r : duty0_r;
  assign second_pwm_output_if.duty = duty1_r;

  iop_pwm_chan u_first_pwm_output (
    .clock(clock),
    .reset_n(reset_n),
    .pwm(first_pwm_output_if.chan)
  );

  iop_pwm_chan u_second_pwm_output (
    .clock(clock),
    .reset_n(reset_n),
    .pwm(second_pwm_output_if.chan)
  );

  logic [10:0] clk32_cnt_r; // Half-period counter
  logic [10:0] clk32_cnt_nxt;
  logic clk32_r;            // 32.768 kHz square wave
  logic clk32_nxt;
  logic first_pwm_output_nxt;
  logic second_pwm_output_nxt;

  // Clock divider and output selection
  always_comb begin
    clk32_cnt_nxt = clk32_cnt_r + 11'h001;
    clk32_nxt = clk32_r;
    if (clk32_cnt_r == 11'(`IOP_CLK32_HALF_CYC - 1)) begin
      clk32_cnt_nxt = 11'h000;
      clk32_nxt = ~clk32_r;
    end
    unique case (line_ten_function)
      `IOP_FN_RSSI_PWM: first_pwm_output_nxt = first_pwm_output_if.pwm_out & rssi_active;
      `IOP_FN_PWM: first_pwm_output_nxt = first_pwm_output_if.pwm_out;
      default: first_pwm_output_nxt = 1'b0;
    endcase
    unique case (line_eleven_function)
      `IOP_FN_CLK32: second_pwm_output_nxt = clk32_r;
      `IOP_FN_PWM: second_pwm_output_nxt = second_pwm_output_if.pwm_out;
      default: second_pwm_output_nxt = 1'b0;
    endcase
  end

  // Register divider and PWM lines
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      clk32_cnt_r <= 11'h000;
      clk32_r <= 1'b0;
      first_pwm_output <= 1'b0;
      second_pwm_output <= 1'b0;
    end else begin
      clk32_cnt_r <= clk32_cnt_nxt;
      clk32_r <= clk32_nxt;
      first_pwm_output <= first_pwm_output_nxt;
      second_pwm_output <= second_pwm_output_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Join indicator LED
  // --------------------------------------------------------------------
  logic [23:0] blink_pre_r;  // Cycles within a 10 ms step
  logic [23:0] blink_pre_nxt;
  logic [7:0] blink_steps_r; // Steps in this phase
  logic [7:0] blink_steps_nxt;
  logic [7:0] phase_steps;   // Steps per phase
  logic led_nxt;

  // Phase length from setting or role default
  always_comb begin
    if (blink_r != 8'h00) begin
      phase_steps = blink_r;
    end else if (sleep_coordinator) begin
      phase_steps = 8'(`IOP_BLINK_COORD_STEPS);
    end else begin
      phase_steps = 8'(`IOP_BLINK_OTHER_STEPS);
    end
  end

  // Toggle at the end of each phase while enabled
  always_comb begin
    blink_pre_nxt = blink_pre_r + 24'h000001;
    blink_steps_nxt = blink_steps_r;
    led_nxt = join_led;
    if (line_five_function != `IOP_FN_JOIN_LED) begin
      blink_pre_nxt = 24'h000000;
      blink_steps_nxt = 8'h00;
      led_nxt = 1'b0;
    end else if (blink_pre_r == 24'(BLINK_STEP_CYC - 1)) begin
      blink_pre_nxt = 24'h000000;
      if (blink_steps_r + 8'h01 >= phase_steps) begin
        blink_steps_nxt = 8'h00;
        led_nxt = ~join_led;
      end else begin
        blink_steps_nxt = blink_steps_r + 8'h01;
      end
    end
  end

  // Register LED state
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      blink_pre_r <= 24'h000000;
      blink_steps_r <= 8'h00;
      join_led <= 1'b0;
    end else begin
      blink_pre_r <= blink_pre_nxt;
      blink_steps_r <= blink_steps_nxt;
      join_led <= led_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_tx_seen;
    tx_done;
  endsequence

  sequence s_timer_fresh;
    hold_st_r == iop_pkg::IOP_HOLD_RUN && hold_steps_r == 8'h00 &&
      hold_pre_r == 24'h000000;
  endsequence

  a_pull_off_line: assert property (!pull_en_r[0] |=>
    !io_pull_up[4] && !io_pull_down[4])
    else $error("disabled pull still driven");
  a_pull_low_map: assert property (pull_en_r[0] && pull_dir_r[0] |=>
    io_pull_up[4])
    else $error("mask bit 0 not on line 4");
  a_pull_high_map: assert property (pull_en_r[11] && !pull_dir_r[11] |=>
    io_pull_down[10] && !io_pull_up[10])
    else $error("mask bit 11 not pulling line 10 down");
  a_first_pwm_output_zero_duty: assert property (
    (line_ten_function == `IOP_FN_PWM && duty0_r == 10'h000)[*3]
    |-> !first_pwm_output)
    else $error("first pwm high with zero duty");
  a_second_pwm_output_zero_duty: assert property (
    (line_eleven_function == `IOP_FN_PWM && duty1_r == 10'h000)[*3]
    |-> !second_pwm_output)
    else $error("second pwm high with zero duty");
  a_led_disabled_off: assert property (
    (line_five_function != `IOP_FN_JOIN_LED)[*2] |-> !join_led)
    else $error("led lit while disabled");
  a_led_toggle_step: assert property (
    $changed(join_led) && $past(line_five_function) == `IOP_FN_JOIN_LED
    |-> blink_pre_r == 24'h000000 && blink_steps_r == 8'h00)
    else $error("led toggled off a phase boundary");
  a_blink_refuse: assert property (param_wr_en &&
    param_wr_sel == iop_pkg::IOP_SEL_BLINK && param_wdata[7:0] != 8'h00 &&
    param_wdata[7:0] < `IOP_BLINK_MIN |=> $stable(blink_r))
    else $error("short blink time accepted");
  a_hold_restart: assert property (s_tx_seen |=> s_timer_fresh)
    else $error("hold timer not restarted");
  a_hold_expire: assert property (!tx_done &&
    hold_st_r == iop_pkg::IOP_HOLD_RUN && hold_r != `IOP_HOLD_FOREVER &&
    hold_steps_r >= hold_r |=> hold_st_r == iop_pkg::IOP_HOLD_IDLE)
    else $error("hold timer did not expire");
  a_hold_forever: assert property (
    hold_st_r == iop_pkg::IOP_HOLD_RUN &&
    hold_r == `IOP_HOLD_FOREVER |=> hold_st_r == iop_pkg::IOP_HOLD_RUN)
    else $error("permanent hold timed out");
  a_rssi_gate: assert property (
    (line_ten_function == `IOP_FN_RSSI_PWM && !rssi_active)[*3]
    |-> !first_pwm_output)
    else $error("strength pwm driven after hold");

endmodule

// *** verilog/iop_defines.svh ***
// Constants for the I/O pull, PWM, join LED and signal-strength timer block
`ifndef IOP_DEFINES_SVH
`define IOP_DEFINES_SVH

// ----------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------
`define IOP_CLK_PERIOD_NS 8

// ----------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------
`define IOP_LINES 20
`define IOP_PULL_EN_RST 20'hFFFFF
`define IOP_PULL_DIR_RST 20'h00000
`define IOP_DUTY_RST 10'h000
`define IOP_BLINK_RST 8'h00
`define IOP_BLINK_MIN 8'h14
`define IOP_HOLD_RST 8'h28
`define IOP_HOLD_FOREVER 8'hFF

// ----------------------------------------------------------------------
// Pin function codes
// ----------------------------------------------------------------------
`define IOP_FN_RSSI_PWM 3'h1
`define IOP_FN_PWM 3'h2
`define IOP_FN_CLK32 3'h1
`define IOP_FN_JOIN_LED 3'h1

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define IOP_BLINK_STEP_MS 10
`define IOP_HOLD_STEP_MS 100
`define IOP_BLINK_COORD_MS 500
`define IOP_BLINK_OTHER_MS 250
`define IOP_BLINK_STEP_CYC (`IOP_BLINK_STEP_MS * 1000000 / `IOP_CLK_PERIOD_NS)
`define IOP_HOLD_STEP_CYC (`IOP_HOLD_STEP_MS * 1000000 / `IOP_CLK_PERIOD_NS)
`define IOP_BLINK_COORD_STEPS (`IOP_BLINK_COORD_MS / `IOP_BLINK_STEP_MS)
`define IOP_BLINK_OTHER_STEPS (`IOP_BLINK_OTHER_MS / `IOP_BLINK_STEP_MS)
`define IOP_CLK32_HZ 32768
`define IOP_CLK32_HALF_CYC \
  (1000000000 / (2 * `IOP_CLK32_HZ * `IOP_CLK_PERIOD_NS))

`endif

// *** verilog/iop_pkg.sv ***
// Types and the pull bit to I/O line map for the I/O block
package iop_pkg;

  // Parameter selector on the command port
  typedef enum logic [2:0] {
    IOP_SEL_PULL_EN  = 3'h0,
    IOP_SEL_PULL_DIR = 3'h1,
    IOP_SEL_DUTY0    = 3'h2,
    IOP_SEL_DUTY1    = 3'h3,
    IOP_SEL_BLINK    = 3'h4,
    IOP_SEL_HOLD     = 3'h5
  } iop_param_t;

  // Signal-strength hold timer states
  typedef enum logic [1:0] {
    IOP_HOLD_IDLE = 2'b01,
    IOP_HOLD_RUN  = 2'b10
  } iop_hold_st_t;

  // I/O line served by a pull mask bit
  function automatic logic [4:0] iop_line_of_bit(input logic [4:0] b);
    unique case (b)
      5'h00: iop_line_of_bit = 5'h04;
      5'h01: iop_line_of_bit = 5'h03;
      5'h02: iop_line_of_bit = 5'h02;
      5'h03: iop_line_of_bit = 5'h01;
      5'h04: iop_line_of_bit = 5'h00;
      5'h05: iop_line_of_bit = 5'h06;
      5'h06: iop_line_of_bit = 5'h08;
      5'h07: iop_line_of_bit = 5'h0E;
      5'h08: iop_line_of_bit = 5'h05;
      5'h09: iop_line_of_bit = 5'h09;
      5'h0A: iop_line_of_bit = 5'h0C;
      5'h0B: iop_line_of_bit = 5'h0A;
      5'h0C: iop_line_of_bit = 5'h0B;
      5'h0D: iop_line_of_bit = 5'h07;
      5'h0E: iop_line_of_bit = 5'h0D;
      default: iop_line_of_bit = b;
    endcase
  endfunction

endpackage

// *** verilog/iop_pwm_if.sv ***
// Duty and output pair between the top and one PWM channel
`timescale 1ns/1ps
interface iop_pwm_if;
  logic [9:0] duty; // Programmed high ticks
  logic pwm_out;    // Registered channel output
  modport owner (output duty, input pwm_out);
  modport chan (input duty, output pwm_out);
endinterface

// *** verilog/iop_pwm_chan.sv ***
// One 10-bit PWM channel with a 1024-tick period
`timescale 1ns/1ps
module iop_pwm_chan (
  input wire logic clock,
  input wire logic reset_n,
  iop_pwm_if.chan pwm
);

  // --------------------------------------------------------------------
  // Period counter and output
  // --------------------------------------------------------------------
  logic [9:0] cnt_r; // Tick within the period
  logic [9:0] cnt_nxt;
  logic out_r;       // Output level
  logic out_nxt;

  // High while the tick is below the duty value
  always_comb begin
    cnt_nxt = cnt_r + 10'h001;
    out_nxt = (cnt_r < pwm.duty);
  end

  // Register counter and level
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= 10'h000;
      out_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
    end
  end

  assign pwm.pwm_out = out_r;

  // Zero duty never drives high
  a_zero_duty_low: assert property (@(posedge clock) disable iff (!reset_n)
    (pwm.duty == 10'h000) |=> !out_r)
    else $error("pwm high with zero duty");

endmodule

// *** sim/tb.sv ***
// Self-checking bench for the pull, PWM, join LED and hold timer block
`timescale 1ns/1ps
module tb;
  // ----------------------------------------------------------------
  // Signals and bookkeeping
  // ----------------------------------------------------------------
  localparam int BLINK_CYC = 4; // Shortened blink step
  localparam int HOLD_CYC = 8; // Shortened hold step
  localparam int CLK32_HALF = 1907; // Half period of the slow clock
  typedef struct {string name; int kind; logic [19:0] exp;} iop_tb_note_t;
  logic clock, reset_n, param_wr_en, sleep_coordinator, tx_done, rssi_valid;
  iop_pkg::iop_param_t param_wr_sel, param_rd_sel;
  logic [19:0] param_wdata, param_rdata, io_pull_up, io_pull_down;
  logic [2:0] line_five_function, line_ten_function, line_eleven_function;
  logic [7:0] rssi_level;
  logic first_pwm_output, second_pwm_output, join_led;
  logic clr_acc; // Restarts the high-time counters
  logic [19:0] acc0, acc1, acc2; // High cycles per output
  logic [19:0] en, dir, up, dn, d0, bl;
  int bad_count, n_compared;
  iop_tb_note_t notes[$]; // Expected results, oldest first
  iop_tb_note_t note;
  logic [19:0] rst_val[8] = '{20'hFFFFF, 20'h0, 20'h0, 20'h0, 20'h0,
                              20'h28, 20'h0, 20'h0};

  iop_top #(.BLINK_STEP_CYC(BLINK_CYC), .HOLD_STEP_CYC(HOLD_CYC)) i_iop_top (
    .clock(clock), .reset_n(reset_n), .param_wr_en(param_wr_en),
    .param_wr_sel(param_wr_sel), .param_wdata(param_wdata),
    .param_rd_sel(param_rd_sel), .param_rdata(param_rdata),
    .line_five_function(line_five_function),
    .line_ten_function(line_ten_function),
    .line_eleven_function(line_eleven_function),
    .sleep_coordinator(sleep_coordinator), .tx_done(tx_done),
    .rssi_valid(rssi_valid), .rssi_level(rssi_level),
    .io_pull_up(io_pull_up), .io_pull_down(io_pull_down),
    .first_pwm_output(first_pwm_output),
    .second_pwm_output(second_pwm_output), .join_led(join_led)
  );

  // ----------------------------------------------------------------
  // Clock and helpers
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // I/O line served by a mask bit
  function automatic int line_of(input int b);
    int m[15] = '{4, 3, 2, 1, 0, 6, 8, 14, 5, 9, 12, 10, 11, 7, 13};
    return (b < 15) ? m[b] : b;
  endfunction

  // Compare one value and count it
  task automatic check(input string name, input logic [19:0] seen,
                       input logic [19:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Step n edges, then drive just after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic note_it(input string name, input int kind,
                         input logic [19:0] exp);
    notes.push_back('{name, kind, exp});
  endtask

  // One parameter write, then one idle edge
  task automatic wr(input iop_pkg::iop_param_t sel, input logic [19:0] d);
    param_wr_en = 1'b1;
    param_wr_sel = sel;
    param_wdata = d;
    tick(1);
    param_wr_en = 1'b0;
    tick(1);
  endtask

  task automatic rd(input iop_pkg::iop_param_t sel, input logic [19:0] exp);
    param_rd_sel = sel;
    tick(2);
    note_it("readback", 0, exp);
  endtask

  // Clears the high-time counters and waits a window
  task automatic window(input int n);
    clr_acc = 1'b1;
    tick(1);
    clr_acc = 1'b0;
    tick(n);
  endtask

  task automatic summarize;
    repeat (2) @(negedge clock);
    if (bad_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Output watcher: counts high cycles and settles queued notes
  // ----------------------------------------------------------------
  always @(negedge clock) begin
    if (clr_acc) begin
      acc0 <= 20'h0;
      acc1 <= 20'h0;
      acc2 <= 20'h0;
    end else begin
      acc0 <= acc0 + 20'(first_pwm_output);
      acc1 <= acc1 + 20'(second_pwm_output);
      acc2 <= acc2 + 20'(join_led);
    end
    while (notes.size() > 0) begin
      note = notes.pop_front();
      case (note.kind)
        0: check(note.name, param_rdata, note.exp);
        1: check(note.name, io_pull_up, note.exp);
        2: check(note.name, io_pull_down, note.exp);
        3: check(note.name, acc0, note.exp);
        4: check(note.name, acc1, note.exp);
        default: check(note.name, acc2, note.exp);
      endcase
    end
  end

  // Hang guard
  initial begin
    repeat (60000) @(posedge clock);
    bad_count++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    {param_wr_en, sleep_coordinator, tx_done, rssi_valid, clr_acc} = 5'h0;
    param_wr_sel = iop_pkg::IOP_SEL_PULL_EN;
    param_rd_sel = iop_pkg::IOP_SEL_PULL_EN;
    param_wdata = 20'h0;
    {line_five_function, line_ten_function, line_eleven_function} = 9'h0;
    rssi_level = 8'h0;
    void'($urandom(32'h67A5));
    repeat (6) @(posedge clock);
    #1 reset_n = 1'b1;
    tick(1);
    for (int s = 0; s < 8; s++)
      rd(iop_pkg::iop_param_t'(s), rst_val[s]);
    note_it("pull down", 2, 20'hFFFFF);
    note_it("pull up", 1, 20'h0);
    // Random values written, read back and mapped onto the lines
    repeat (4) begin
      en = $urandom & 20'hFFFFF;
      dir = $urandom & 20'hFFFFF;
      d0 = $urandom & 20'h3FF;
      bl = 20'h14 + $urandom_range(0, 20'hEB);
      wr(iop_pkg::IOP_SEL_PULL_EN, en);
      wr(iop_pkg::IOP_SEL_PULL_DIR, dir);
      wr(iop_pkg::IOP_SEL_DUTY0, d0 | 20'hFFC00);
      wr(iop_pkg::IOP_SEL_DUTY1, d0 ^ 20'h3FF);
      wr(iop_pkg::IOP_SEL_BLINK, bl);
      wr(iop_pkg::IOP_SEL_BLINK, 20'h13);
      wr(iop_pkg::IOP_SEL_HOLD, d0 & 20'hFF);
      wr(iop_pkg::iop_param_t'(3'h6), 20'hFFFFF);
      rd(iop_pkg::IOP_SEL_PULL_EN, en);
      rd(iop_pkg::IOP_SEL_PULL_DIR, dir);
      rd(iop_pkg::IOP_SEL_DUTY0, d0);
      rd(iop_pkg::IOP_SEL_DUTY1, d0 ^ 20'h3FF);
      rd(iop_pkg::IOP_SEL_BLINK, bl);
      rd(iop_pkg::IOP_SEL_HOLD, d0 & 20'hFF);
      rd(iop_pkg::iop_param_t'(3'h6), 20'h0);
      for (int b = 0; b < 20; b++) begin
        up[line_of(b)] = en[b] & dir[b];
        dn[line_of(b)] = en[b] & ~dir[b];
      end
      note_it("pull up", 1, up);
      note_it("pull down", 2, dn);
    end
    // Plain PWM on both lines over whole periods
    line_ten_function = 3'h2;
    line_eleven_function = 3'h2;
    foreach (rst_val[i]) begin
      d0 = (i == 0) ? 20'h0 : (i == 1) ? 20'h3FF : (i == 2) ? 20'h1 :
           ($urandom & 20'h3FF);
      wr(iop_pkg::IOP_SEL_DUTY0, d0);
      wr(iop_pkg::IOP_SEL_DUTY1, d0 ^ 20'h3FF);
      tick(4);
      window(1024);
      note_it("first pwm", 3, d0);
      note_it("second pwm", 4, d0 ^ 20'h3FF);
    end
    line_ten_function = 3'h0;
    line_eleven_function = 3'h1;
    tick(4);
    window(4 * CLK32_HALF);
    note_it("first pwm off", 3, 20'h0);
    note_it("slow clock", 4, 20'(2 * CLK32_HALF));
    // Signal-strength output and its hold timer
    rssi_level = 8'h80;
    rssi_valid = 1'b1;
    tick(1);
    rssi_valid = 1'b0;
    line_ten_function = 3'h1;
    wr(iop_pkg::IOP_SEL_HOLD, 20'hFF);
    // A transmission under the permanent setting never times out
    tx_done = 1'b1;
    tick(1);
    tx_done = 1'b0;
    window(1024);
    note_it("strength forever", 3, 20'h202);
    // Zero hold lets the running timer lapse at once
    wr(iop_pkg::IOP_SEL_HOLD, 20'h0);
    tick(4);
    window(1024);
    note_it("strength idle", 3, 20'h0);
    wr(iop_pkg::IOP_SEL_HOLD, 20'hC8);
    tx_done = 1'b1;
    tick(1);
    tx_done = 1'b0;
    tick(1000);
    rssi_level = 8'hFF;
    {rssi_valid, tx_done} = 2'b11;
    tick(1);
    {rssi_valid, tx_done} = 2'b00;
    tick(200);
    window(1024);
    note_it("strength held", 3, 20'h3FF);
    tick(600);
    window(1024);
    note_it("strength expired", 3, 20'h0);
    // Join LED phases
    line_five_function = 3'h1;
    wr(iop_pkg::IOP_SEL_BLINK, 20'h14);
    tick(400);
    window(40 * BLINK_CYC);
    note_it("led half", 5, 20'(20 * BLINK_CYC));
    window(400 * BLINK_CYC);
    note_it("led long", 5, 20'(200 * BLINK_CYC));
    wr(iop_pkg::IOP_SEL_BLINK, 20'h0);
    tick(400);
    window(50 * BLINK_CYC);
    note_it("led default", 5, 20'(25 * BLINK_CYC));
    sleep_coordinator = 1'b1;
    tick(800);
    window(100 * BLINK_CYC);
    note_it("led coordinator", 5, 20'(50 * BLINK_CYC));
    line_five_function = 3'h3;
    tick(2);
    window(200);
    note_it("led off", 5, 20'h0);
    summarize();
  end
endmodule
